//--- hdl/oss_cfg.svh
// oscillator source select: offsets, field positions, reset values, counts
// assumes APB with 32-bit data; each register one aligned word
`ifndef OSS_CFG_SVH
`define OSS_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OSS_ADDR_CTRL 12'h000
`define OSS_ADDR_TRIM 12'h004
`define OSS_ADDR_STAT 12'h008

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define OSS_CUR_HI 14
`define OSS_CUR_LO 12
`define OSS_NXT_HI 10
`define OSS_NXT_LO 8
`define OSS_LOCK_BIT 5
`define OSS_KEEP_BIT 1

// ----------------------------------------------------------------------
// trim and status fields
// ----------------------------------------------------------------------
`define OSS_TRIM_HI 3
`define OSS_TRIM_LO 0
`define OSS_ST_RELEASED 0
`define OSS_ST_BUSY 1
`define OSS_ST_SLOWRC 2
`define OSS_ST_WATCH 3
`define OSS_ST_FASTRC 4

// ----------------------------------------------------------------------
// group codes and reset values
// ----------------------------------------------------------------------
`define OSS_GRP_WATCH 3'h0
`define OSS_GRP_FASTRC 3'h1
`define OSS_GRP_SLOWRC 3'h2
`define OSS_GRP_PRIMARY 3'h3
`define OSS_GRP_PLL 3'h7
`define OSS_RST_GROUP 3'h1
`define OSS_RST_TRIM 4'h0
`define OSS_RST_KEEP 1'b0

// ----------------------------------------------------------------------
// start-up timer: 1024 oscillator periods on a 10-bit counter
// ----------------------------------------------------------------------
`define OSS_STARTUP_PERIODS 1024
`define OSS_STARTUP_LAST 10'h3FF

`endif

//--- hdl/oss_pkg.sv
// oscillator source select: shared types
// assumes oss_cfg.svh supplies the numeric constants
package oss_pkg;

  // ----------------------------------------------------------------------
  // PLL gain, PLL input, output-pin use and switch state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    OSS_PLL_OFF = 2'h0,
    OSS_PLL_X4 = 2'h1,
    OSS_PLL_X8 = 2'h2,
    OSS_PLL_X16 = 2'h3
  } oss_pll_gain_t;

  typedef enum logic [2:0] {
    OSS_SRC_FASTRC = 3'h0,
    OSS_SRC_MIDXTAL = 3'h1,
    OSS_SRC_EXTCLK = 3'h3,
    OSS_SRC_FAST_DIV2 = 3'h4,
    OSS_SRC_FAST_DIV3 = 3'h5,
    OSS_SRC_NONE = 3'h7
  } oss_pll_src_t;

  typedef enum logic [1:0] {
    OSS_PIN_IO = 2'h0,
    OSS_PIN_OSC = 2'h1,
    OSS_PIN_CLOCK_OUT_PIN = 2'h2,
    OSS_PIN_UNUSED = 2'h3
  } oss_pin_fn_t;

  typedef enum logic [1:0] {
    OSS_SW_IDLE = 2'h0,
    OSS_SW_WAIT = 2'h1
  } oss_sw_state_t;

  // decoded primary mode, carried as one unit
  typedef struct packed {
    logic crystal;
    oss_pll_gain_t gain;
    oss_pll_src_t pllSrc;
    oss_pin_fn_t pinFn;
  } oss_mode_t;

endpackage

//--- hdl/oss_startup_timer.sv
// oscillator start-up timer: counts oscillator periods before release
// assumes tick is a one-cycle enable, one per oscillator period
`include "oss_cfg.svh"

module oss_startup_timer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic tick,
  output logic done
);

  logic [9:0] count_q;

  // ----------------------------------------------------------------------
  // 10-bit count; done after the last of 1024 periods
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 10'h000;
      done <= 1'b0;
    end else if (clear) begin
      count_q <= 10'h000; // [RULE_20]
      done <= 1'b0; // [RULE_20]
    end else if (tick && !done) begin
      count_q <= count_q + 10'h001; // [RULE_02]
      if (count_q == `OSS_STARTUP_LAST) begin
        done <= 1'b1; // [RULE_02]
      end
    end
  end

endmodule // oss_startup_timer

//--- hdl/oss_top.sv
// oscillator source select: group decode, start-up gating, PLL choice,
// watch oscillator, slow RC keep-alive, trim and pin use; APB slave
// assumes all inputs synchronous to clk_sys; oscTick is one pulse per
// period of the oscillator being started; config inputs are fuse levels
`include "oss_cfg.svh"

// Contract
// [RULE_01] clock chosen from group and primary mode
// [RULE_02] 10-bit timer counts 1024 oscillator periods
// [RULE_03] delay for crystal modes on every restart
// [RULE_04] group code decodes to four groups
// [RULE_05] PLL gain and input from mode bits
// [RULE_06] primary external mode field decode
// [RULE_07] partner keeps PLL input within range
// [RULE_08] lock bit follows PLL lock, read-only
// [RULE_09] fast RC runs when current group 01
// [RULE_10] 4-bit signed trim steps fast RC
// [RULE_11] software keeps trimmed RC under 7.5 MHz
// [RULE_12] watch oscillator runs whenever keep-on set
// [RULE_13] watch clock only with group 00, keep-on
// [RULE_14] returning to main osc incurs start-up delay
// [RULE_15] slow RC always on at power-on
// [RULE_16] slow RC stays on only when needed
// [RULE_17] output pin use follows primary mode
// [RULE_18] input pin never general-purpose I/O
// [RULE_19] current and next group loaded at reset
// [RULE_20] timer cleared on each primary restart
module oss_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] cfgGroupSel,
  input wire logic [4:0] cfgPrimaryMode,
  input wire logic cfgFailMonEn,
  input wire logic cfgWatchdogEn,
  input wire logic porEvent,
  input wire logic wakeEvent,
  input wire logic sleepMode,
  input wire logic powerUpExpired,
  input wire logic oscTick,
  input wire logic pllLockIn,
  output logic clkReleased,
  output logic [2:0] sysGroup,
  output oss_pkg::oss_mode_t primaryMode,
  output logic fastRcRun,
  output logic slowRcRun,
  output logic watchOscRun,
  output logic watchIsClock,
  output logic primaryOscRun,
  output logic [3:0] rcTrim,
  output logic inPinIoEn
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic initDone_q;
  logic [2:0] curGroup_q;
  logic [2:0] nextGroup_q;
  logic keepOn_q;
  logic [3:0] trim_q;
  logic lock_q;
  oss_pkg::oss_sw_state_t swState_q;
  oss_pkg::oss_mode_t modeDec;
  logic loadCfg;
  logic apbSetup;
  logic apbWrite;
  logic ctrlWrite;
  logic trimWrite;
  logic switchReq;
  logic targetNeedsStart;
  logic curNeedsStart;
  logic restart;
  logic timerDone;
  logic pllUsed;
  logic readyForUse;
  logic [31:0] rdData;
  logic rdHit;

  // power-on/brown-out event or first cycle after reset release
  assign loadCfg = porEvent || !initDone_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      initDone_q <= 1'b0;
    end else begin
      initDone_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // primary mode decode
  // ----------------------------------------------------------------------
  function automatic oss_pkg::oss_mode_t decodeMode(
    input logic [2:0] grp,
    input logic [4:0] mode
  );
    oss_pkg::oss_mode_t m;
    m.crystal = 1'b0;
    m.gain = oss_pkg::OSS_PLL_OFF;
    m.pllSrc = oss_pkg::OSS_SRC_NONE;
    m.pinFn = oss_pkg::OSS_PIN_UNUSED;
    if (grp == `OSS_GRP_PLL) begin
      case (mode[1:0]) // [RULE_05]
        2'h1: m.gain = oss_pkg::OSS_PLL_X4;
        2'h2: m.gain = oss_pkg::OSS_PLL_X8;
        2'h3: m.gain = oss_pkg::OSS_PLL_X16;
        default: m.gain = oss_pkg::OSS_PLL_OFF;
      endcase
      case (mode[4:2]) // [RULE_05]
        3'h0: begin
          m.pllSrc = oss_pkg::OSS_SRC_FASTRC;
          m.pinFn = oss_pkg::OSS_PIN_IO;
        end
        3'h1: begin
          m.pllSrc = oss_pkg::OSS_SRC_MIDXTAL;
          m.crystal = 1'b1;
          m.pinFn = oss_pkg::OSS_PIN_OSC;
        end
        3'h3: begin
          m.pllSrc = oss_pkg::OSS_SRC_EXTCLK;
          m.pinFn = oss_pkg::OSS_PIN_IO;
        end
        3'h4: begin
          m.pllSrc = oss_pkg::OSS_SRC_FAST_DIV2;
          m.crystal = 1'b1;
          m.pinFn = oss_pkg::OSS_PIN_OSC;
        end
        3'h5: begin
          m.pllSrc = oss_pkg::OSS_SRC_FAST_DIV3;
          m.crystal = 1'b1;
          m.pinFn = oss_pkg::OSS_PIN_OSC;
        end
        default: m.pllSrc = oss_pkg::OSS_SRC_NONE;
      endcase
    end else begin
      case (mode) // [RULE_06] [RULE_17]
        5'h00, 5'h04, 5'h02: begin
          m.crystal = 1'b1; // low, mid, fast crystal
          m.pinFn = oss_pkg::OSS_PIN_OSC;
        end
        5'h0B, 5'h09: m.pinFn = oss_pkg::OSS_PIN_CLOCK_OUT_PIN;
        5'h0C, 5'h08: m.pinFn = oss_pkg::OSS_PIN_IO;
        default: m.pinFn = oss_pkg::OSS_PIN_UNUSED;
      endcase
    end
    return m;
  endfunction

  // mode field comes from fuses, so the decode keys on the fuse group
  assign modeDec = decodeMode(cfgGroupSel, cfgPrimaryMode); // [RULE_01]

  function automatic logic needsStart(
    input logic [2:0] grp,
    input oss_pkg::oss_mode_t m
  );
    // watch crystal, or primary/PLL group with a crystal mode
    needsStart = (grp == `OSS_GRP_WATCH) ||
      (((grp == `OSS_GRP_PRIMARY) || (grp == `OSS_GRP_PLL)) &&
      m.crystal); // [RULE_03]
  endfunction

  assign targetNeedsStart = needsStart(nextGroup_q, modeDec);
  assign curNeedsStart = needsStart(curGroup_q, modeDec);
  assign pllUsed = (curGroup_q == `OSS_GRP_PLL) &&
    (modeDec.gain != oss_pkg::OSS_PLL_OFF);

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite;
  assign ctrlWrite = apbWrite && (paddr == `OSS_ADDR_CTRL);
  assign trimWrite = apbWrite && (paddr == `OSS_ADDR_TRIM);

  // ----------------------------------------------------------------------
  // group selection and switching
  // ----------------------------------------------------------------------
  assign switchReq = (swState_q == oss_pkg::OSS_SW_IDLE) && !loadCfg &&
    (nextGroup_q != curGroup_q);

  // restart the start-up count on power-on/brown-out, wake, or a switch
  // toward a crystal group, including back from the watch oscillator
  assign restart = (loadCfg && needsStart(cfgGroupSel, modeDec)) ||
    (wakeEvent && curNeedsStart) ||
    (switchReq && targetNeedsStart); // [RULE_03] [RULE_14] [RULE_20]

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      curGroup_q <= `OSS_RST_GROUP;
      nextGroup_q <= `OSS_RST_GROUP;
    end else if (loadCfg) begin
      curGroup_q <= cfgGroupSel; // [RULE_19]
      nextGroup_q <= cfgGroupSel; // [RULE_19]
    end else begin
      if (ctrlWrite) begin
        nextGroup_q <= pwdata[`OSS_NXT_HI:`OSS_NXT_LO];
      end
      if (switchReq && !targetNeedsStart) begin
        curGroup_q <= nextGroup_q;
      end else if ((swState_q == oss_pkg::OSS_SW_WAIT) && timerDone) begin
        curGroup_q <= nextGroup_q; // [RULE_14]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      swState_q <= oss_pkg::OSS_SW_IDLE;
    end else begin
      case (swState_q)
        oss_pkg::OSS_SW_IDLE: begin
          if (switchReq && targetNeedsStart) begin
            swState_q <= oss_pkg::OSS_SW_WAIT;
          end
        end
        oss_pkg::OSS_SW_WAIT: begin
          if (loadCfg || timerDone) begin
            swState_q <= oss_pkg::OSS_SW_IDLE;
          end
        end
        default: swState_q <= oss_pkg::OSS_SW_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // start-up timer
  // ----------------------------------------------------------------------
  oss_startup_timer u_startup_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(restart),
    .tick(oscTick),
    .done(timerDone)
  );

  // ----------------------------------------------------------------------
  // software controls and lock status
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      keepOn_q <= `OSS_RST_KEEP;
    end else if (ctrlWrite) begin
      keepOn_q <= pwdata[`OSS_KEEP_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trim_q <= `OSS_RST_TRIM;
    end else if (trimWrite) begin
      trim_q <= pwdata[`OSS_TRIM_HI:`OSS_TRIM_LO]; // [RULE_10]
    end
  end

  // lock follows the loop both ways; no latching of a lost lock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= pllUsed && pllLockIn; // [RULE_08]
    end
  end

  // ----------------------------------------------------------------------
  // clock release and oscillator enables
  // ----------------------------------------------------------------------
  assign readyForUse = (!curNeedsStart || timerDone) &&
    (!pllUsed || lock_q) && (swState_q == oss_pkg::OSS_SW_IDLE);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clkReleased <= 1'b0;
    end else if (restart || loadCfg) begin
      clkReleased <= 1'b0; // [RULE_20]
    end else begin
      clkReleased <= readyForUse; // [RULE_02] [RULE_03]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sysGroup <= `OSS_RST_GROUP;
      primaryMode <= '0;
      inPinIoEn <= 1'b0;
      rcTrim <= `OSS_RST_TRIM;
    end else begin
      sysGroup <= curGroup_q; // [RULE_04]
      primaryMode <= modeDec; // [RULE_17]
      inPinIoEn <= 1'b0; // [RULE_18]
      rcTrim <= trim_q; // [RULE_10]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fastRcRun <= 1'b0;
      watchOscRun <= 1'b0;
      watchIsClock <= 1'b0;
      primaryOscRun <= 1'b0;
    end else begin
      // fast RC also feeds the PLL when that is the PLL input
      fastRcRun <= (curGroup_q[1:0] == 2'h1) ||
        (pllUsed && modeDec.pllSrc == oss_pkg::OSS_SRC_FASTRC); // [RULE_09]
      watchOscRun <= keepOn_q ||
        (curGroup_q[1:0] == 2'h0 && !sleepMode); // [RULE_12]
      watchIsClock <= (curGroup_q[1:0] == 2'h0) && keepOn_q; // [RULE_13]
      primaryOscRun <= !sleepMode &&
        ((curGroup_q == `OSS_GRP_PRIMARY) ||
        (curGroup_q == `OSS_GRP_PLL) ||
        ((swState_q == oss_pkg::OSS_SW_WAIT) &&
        (nextGroup_q != `OSS_GRP_WATCH)));
    end
  end

  // slow RC runs from reset until the power-up delay has passed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slowRcRun <= 1'b1; // [RULE_15]
    end else if (!powerUpExpired) begin
      slowRcRun <= 1'b1; // [RULE_15]
    end else begin
      slowRcRun <= cfgFailMonEn || cfgWatchdogEn ||
        (curGroup_q[1:0] == 2'h2); // [RULE_16]
    end
  end

  // ----------------------------------------------------------------------
  // APB read data and handshake: one wait-free access phase
  // ----------------------------------------------------------------------
  always_comb begin
    rdData = 32'h0000_0000;
    rdHit = 1'b1;
    case (paddr)
      `OSS_ADDR_CTRL: begin
        rdData[`OSS_CUR_HI:`OSS_CUR_LO] = curGroup_q;
        rdData[`OSS_NXT_HI:`OSS_NXT_LO] = nextGroup_q;
        rdData[`OSS_LOCK_BIT] = lock_q; // [RULE_08]
        rdData[`OSS_KEEP_BIT] = keepOn_q;
      end
      `OSS_ADDR_TRIM: rdData[`OSS_TRIM_HI:`OSS_TRIM_LO] = trim_q;
      `OSS_ADDR_STAT: begin
        rdData[`OSS_ST_RELEASED] = clkReleased;
        rdData[`OSS_ST_BUSY] = (swState_q != oss_pkg::OSS_SW_IDLE);
        rdData[`OSS_ST_SLOWRC] = slowRcRun;
        rdData[`OSS_ST_WATCH] = watchIsClock;
        rdData[`OSS_ST_FASTRC] = fastRcRun;
      end
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (apbSetup) begin
      pready <= 1'b1;
      pslverr <= !rdHit;
      prdata <= (pwrite || !rdHit) ? 32'h0000_0000 : rdData;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // oss_top

//--- tb/oss_top_chk.sv
// checker for oss_top, watching its ports only
// assumes it is bound into every oss_top instance
module oss_top_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] cfgGroupSel,
  input wire logic [4:0] cfgPrimaryMode,
  input wire logic cfgFailMonEn,
  input wire logic cfgWatchdogEn,
  input wire logic powerUpExpired,
  input wire logic oscTick,
  input wire logic clkReleased,
  input wire logic [2:0] sysGroup,
  input wire oss_pkg::oss_mode_t primaryMode,
  input wire logic fastRcRun,
  input wire logic slowRcRun,
  input wire logic watchIsClock,
  input wire logic inPinIoEn
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // helpers
  // --------
  logic [10:0] tick_q;
  // a tick may slip at release, hence 1023
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) tick_q <= '0;
    else if (clkReleased) tick_q <= '0;
    else if (oscTick && !tick_q[10]) tick_q <= tick_q + 11'h001;
  end
  function automatic logic [2:0] extDec(input logic [4:0] m);
    case (m)
      5'h00, 5'h04, 5'h02: extDec = 3'h5;
      5'h0B, 5'h09: extDec = 3'h2;
      5'h0C, 5'h08: extDec = 3'h0;
      default: extDec = 3'h3;
    endcase
  endfunction
  // --------
  // properties
  // --------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_inpin_never_io: assert property (inPinIoEn == 1'b0)
    else $error("input pin offered as io");
  a_apb_zero_wait: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not in first access cycle");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr > 12'h008))
    else $error("pslverr wrong for address");
  a_startup_count: assert property (
      $rose(clkReleased) && sysGroup == 3'h3 && primaryMode.crystal |->
      tick_q >= 11'h3FF)
    else $error("crystal released before start-up count");
  a_fastrc_runs: assert property ((sysGroup[1:0] == 2'h1)[*2] |->
      fastRcRun) else $error("fast rc stopped in its group");
  a_watch_clock: assert property (watchIsClock |->
      sysGroup == 3'h0 || $past(sysGroup) == 3'h0)
    else $error("watch clock outside group");
  a_slowrc_stop: assert property ((powerUpExpired &&
      !cfgFailMonEn && !cfgWatchdogEn && sysGroup != 3'h2)[*2] |-> !slowRcRun)
    else $error("slow rc left running");
  a_slowrc_keep: assert property ((!powerUpExpired ||
      cfgFailMonEn || cfgWatchdogEn || sysGroup == 3'h2)[*2] |-> slowRcRun)
    else $error("slow rc stopped while needed");
  a_pll_decode: assert property ((cfgGroupSel == 3'h7 &&
      cfgPrimaryMode[1:0] != 2'h0 && $stable(cfgPrimaryMode) &&
      cfgPrimaryMode[4:2] inside {3'h1, 3'h3, 3'h4, 3'h5})[*2] |->
      primaryMode.gain == cfgPrimaryMode[1:0] &&
      primaryMode.pllSrc == cfgPrimaryMode[4:2])
    else $error("pll gain or input wrong");
  a_ext_decode: assert property ((cfgGroupSel == 3'h3 &&
      $stable(cfgPrimaryMode))[*2] |->
      {primaryMode.crystal, primaryMode.pinFn} == extDec(cfgPrimaryMode))
    else $error("external mode decode wrong");
  c_crystal_rel: cover property ($rose(clkReleased) && primaryMode.crystal);
  c_pll_x16: cover property (primaryMode.gain == oss_pkg::OSS_PLL_X16);
  c_unmapped: cover property (pready && pslverr);
endmodule // oss_top_chk

bind oss_top oss_top_chk chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .cfgGroupSel(cfgGroupSel),
  .cfgPrimaryMode(cfgPrimaryMode), .cfgFailMonEn(cfgFailMonEn),
  .cfgWatchdogEn(cfgWatchdogEn), .powerUpExpired(powerUpExpired),
  .oscTick(oscTick), .clkReleased(clkReleased), .sysGroup(sysGroup),
  .primaryMode(primaryMode), .fastRcRun(fastRcRun), .slowRcRun(slowRcRun),
  .watchIsClock(watchIsClock), .inPinIoEn(inPinIoEn));

//--- tb/oss_osc_model.sv
// oscillator and PLL model on the far side of oss_top
// assumes run is the block's oscillator enable, synchronous to clk_sys
module oss_osc_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic slow,
  input wire logic lockDrop,
  output logic oscTick,
  output logic pllLockIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_q;
  logic [4:0] lock_q;
  // a stopped oscillator gives no periods at all
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
      oscTick <= 1'b0;
    end else begin
      div_q <= (run && div_q != (slow ? 3'h4 : 3'h1)) ? div_q + 3'h1 : 3'h0;
      oscTick <= run && div_q == 3'h0;
    end
  end
  // input always in band, so lock follows a short settling span
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) lock_q <= '0;
    else if (!run || lockDrop) lock_q <= '0;
    else if (!lock_q[4]) lock_q <= lock_q + 5'h01;
  end
  assign pllLockIn = lock_q[4];
endmodule // oss_osc_model

//--- tb/testbench.sv
// self-checking bench for oss_top beside the oscillator model
// assumes zero-wait APB and one clk_sys domain
`include "oss_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [2:0] cfgGroupSel, sysGroup, src;
  logic [4:0] cfgPrimaryMode;
  logic cfgFailMonEn, cfgWatchdogEn, porEvent, wakeEvent, sleepMode;
  logic powerUpExpired, oscTick, pllLockIn, clkReleased, fastRcRun;
  logic slowRcRun, watchOscRun, watchIsClock, primaryOscRun, inPinIoEn;
  logic slow, lockDrop;
  logic [3:0] rcTrim, tv;
  logic [1:0] gn;
  oss_pkg::oss_mode_t primaryMode;
  int failures, num_checks, tickCnt, n, t0;
  logic [4:0] modes [7] = '{5'h00, 5'h04, 5'h02, 5'h0B, 5'h0C, 5'h09, 5'h08};
  logic [2:0] srcs [4] = '{3'h1, 3'h3, 3'h4, 3'h5};
  logic [2:0] grps [3] = '{3'h0, 3'h2, 3'h1};

  oss_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfgGroupSel(cfgGroupSel), .cfgPrimaryMode(cfgPrimaryMode),
    .cfgFailMonEn(cfgFailMonEn), .cfgWatchdogEn(cfgWatchdogEn),
    .porEvent(porEvent), .wakeEvent(wakeEvent), .sleepMode(sleepMode),
    .powerUpExpired(powerUpExpired), .oscTick(oscTick),
    .pllLockIn(pllLockIn), .clkReleased(clkReleased), .sysGroup(sysGroup),
    .primaryMode(primaryMode), .fastRcRun(fastRcRun),
    .slowRcRun(slowRcRun), .watchOscRun(watchOscRun),
    .watchIsClock(watchIsClock), .primaryOscRun(primaryOscRun),
    .rcTrim(rcTrim), .inPinIoEn(inPinIoEn));
  oss_osc_model osc (.clk_sys(clk_sys), .rst_n(rst_n),
    .run(primaryOscRun | watchOscRun), .slow(slow), .lockDrop(lockDrop),
    .oscTick(oscTick), .pllLockIn(pllLockIn));

  // --------
  // helpers
  // --------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [2:0] modeExp(input logic [4:0] m);
    case (m)
      5'h00, 5'h04, 5'h02: modeExp = 3'h5;
      5'h0B, 5'h09: modeExp = 3'h2;
      5'h0C, 5'h08: modeExp = 3'h0;
      default: modeExp = 3'h3;
    endcase
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    if (failures == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // restart from fuses, or wake from sleep; n gets the ticks spent
  task automatic restart(logic [2:0] g, logic [4:0] m, logic wake);
    @(posedge clk_sys);
    cfgGroupSel <= g;
    cfgPrimaryMode <= m;
    sleepMode <= wake;
    @(posedge clk_sys);
    wakeEvent <= wake;
    porEvent <= !wake;
    sleepMode <= 1'b0;
    @(posedge clk_sys);
    wakeEvent <= 1'b0;
    porEvent <= 1'b0;
    t0 = tickCnt;
    repeat (3) @(posedge clk_sys);
    while (clkReleased !== 1'b1) @(posedge clk_sys);
    n = tickCnt - t0;
    @(negedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (oscTick === 1'b1) tickCnt <= tickCnt + 1;
  initial begin
    repeat (95000) @(posedge clk_sys);
    failures++;
    results();
  end

  // --------
  // scenarios
  // --------
  initial begin
    {rst_n, psel, penable, pwrite, porEvent, wakeEvent, sleepMode} = '0;
    {cfgFailMonEn, cfgWatchdogEn, powerUpExpired, slow, lockDrop} = '0;
    paddr = '0;
    pwdata = '0;
    cfgGroupSel = 3'h1;
    cfgPrimaryMode = 5'h04;
    seed = 32'h40B70B14;
    {failures, num_checks, tickCnt} = '0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, `OSS_ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h00001100, rd & 32'h00007722);
    apb(1'b0, `OSS_ADDR_STAT, 32'h0);
    chk("slowrc", 32'h4, rd & 32'h4);
    chk("fastrc", 32'h1, fastRcRun);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      tv = (i == 0) ? 4'h0 : (i == 1) ? 4'h7 : (i == 2) ? 4'h8 : seed[3:0];
      apb(1'b1, `OSS_ADDR_TRIM, {seed[31:4], tv});
      apb(1'b1, 12'h100, 32'hFFFFFFFF);
      chk("unmapped", 32'h1, err);
      apb(1'b0, `OSS_ADDR_TRIM, 32'h0);
      chk("trim", {28'h0, tv}, rd);
      chk("rctrim", tv, rcTrim);
    end
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped rd", 32'h0, rd);
    // keep-on, then watch clock, then back to the crystal
    apb(1'b1, `OSS_ADDR_CTRL, 32'h00000102);
    sleepMode <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("watch sleep", 32'h1, watchOscRun);
    chk("watch clk", 32'h0, watchIsClock);
    apb(1'b1, `OSS_ADDR_CTRL, 32'h00000002);
    sleepMode <= 1'b0;
    while (sysGroup !== 3'h0) @(posedge clk_sys);
    repeat (3) @(negedge clk_sys);
    chk("watch is clk", 32'h1, watchIsClock);
    apb(1'b1, `OSS_ADDR_CTRL, 32'h00000302);
    t0 = tickCnt;
    while (sysGroup !== 3'h3) @(posedge clk_sys);
    chk("switch ticks", 32'h1, tickCnt - t0 >= 1023);
    for (int i = 0; i < 7; i++) begin
      slow <= (i == 1);
      restart(3'h3, modes[i], 1'b0);
      chk("ost", (i < 3) ? 32'h100 : 32'h0, n >> 2);
      chk("pin", modeExp(modes[i]),
        {primaryMode.crystal, primaryMode.pinFn});
      chk("prim run", 32'h1, primaryOscRun);
    end
    slow <= 1'b0;
    restart(3'h3, 5'h02, 1'b1);
    chk("wake ost", 32'h1, n >= 1023 && n <= 1027);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      src = srcs[seed[1:0]];
      gn = (seed[3:2] == 2'h0) ? 2'h3 : seed[3:2];
      restart(3'h7, {src, gn}, 1'b0);
      chk("grp pll", 32'h7, sysGroup);
      chk("gain", gn, primaryMode.gain);
      chk("src", src, primaryMode.pllSrc);
      apb(1'b0, `OSS_ADDR_CTRL, 32'h0);
      chk("lock", 32'h20, rd & 32'h20);
      lockDrop <= 1'b1;
      @(posedge clk_sys);
      apb(1'b0, `OSS_ADDR_CTRL, 32'h0);
      chk("unlock", 32'h0, rd & 32'h20);
      lockDrop <= 1'b0;
    end
    @(posedge clk_sys);
    powerUpExpired <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      restart(grps[i], 5'h04, 1'b0);
      chk("grp", grps[i], sysGroup);
      chk("slowsel", grps[i] == 3'h2, slowRcRun);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      cfgWatchdogEn <= i[0];
      cfgFailMonEn <= i[1];
      repeat (4) @(negedge clk_sys);
      chk("slowkeep", i != 0, slowRcRun);
    end
    chk("inpin", 32'h0, inPinIoEn);
    results();
  end
endmodule // testbench
